// ### src/dcf_fifo.sv
// dcf_fifo: dual-clock flagged buffer with threshold flags and AXI4-Lite status
// assumes: write and read clocks arrive as pins and are sampled by aclk,
// which must run well above both; all pins are asynchronous to aclk
//
// Summary of operation
// - master reset zeroes pointers and output word
// - master reset latches mode, default threshold, method
// - partial reset zeroes pointers, keeps mode and thresholds
// - rewind zeroes read pointer, flags empty briefly
// - shared pin: mode at reset, serial bit later
// - write edge stores word, or thresholds when loading
// - serial enable shifts one bit into thresholds
// - read edge presents next word, or thresholds
// - load level at reset picks default 127/1023
// - load pin steers accesses to threshold registers
// - output enable drives or floats read data
// - full pin: full, or input ready in fall-through
// - empty pin: empty, or data valid in fall-through
// - almost-full when count exceeds capacity minus m
// - almost-empty when count below n
// - half-full shows count above half capacity
// - write and read buses eighteen bits wide
// - fall-through first word after three transitions
// - default 127 parallel, default 1023 serial
`timescale 1ns/10ps
`default_nettype none
module dcf_fifo
    import dcf_pkg::*;
#(
    parameter int DATA_W = DATA_W_DEF,
    parameter int ADDR_W = ADDR_W_DEF
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic write_clock,
    input wire logic read_clock,
    input wire logic master_reset_n,
    input wire logic partial_reset_n,
    input wire logic rewind_read_pointer_n,
    input wire logic fall_through_select_serial_in,
    input wire logic write_enable_n,
    input wire logic read_enable_n,
    input wire logic output_enable_n,
    input wire logic serial_load_enable_n,
    input wire logic threshold_access_load_n,
    input wire logic unused_tie_pin,
    input wire logic [DATA_W-1:0] write_data_bus,
    output logic [DATA_W-1:0] read_data_bus,
    output logic read_data_bus_oe_n,
    output logic full_or_input_ready_n,
    output logic empty_or_data_valid_n,
    output logic almost_full_flag_n,
    output logic almost_empty_flag_n,
    output logic half_full_flag_n,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int PW = ADDR_W + 1;
    localparam logic [PW-1:0] DEPTH_V = {1'b1, {ADDR_W{1'b0}}};
    localparam logic [PW-1:0] HALF_V = {2'b01, {(ADDR_W-1){1'b0}}};

    // ------------------------------------------------------------
    // pin synchronisers and edge finders
    // ------------------------------------------------------------
    logic [11:0] pin_raw, pin_s;
    logic [DATA_W-1:0] wdata_s;
    logic wclk_d_q, rclk_d_q;
    logic wr_edge, rd_tr, rd_edge;
    logic mrs_act, prs_act, rt_act, si_s, wen, ren, oe_act, serial_load_enable, ld_act, tie_s;

    assign pin_raw = {write_clock, read_clock, master_reset_n, partial_reset_n,
                      rewind_read_pointer_n, fall_through_select_serial_in,
                      write_enable_n, read_enable_n, output_enable_n,
                      serial_load_enable_n, threshold_access_load_n, unused_tie_pin};

    // data rides the same two-stage delay as the write clock, so it is
    // sampled in step with the edge it belongs to
    dcf_sync #(.W(12), .RST_VAL(12'h3ff)) u_pin_sync (
        .clk(aclk), .rst_n(aresetn), .d(pin_raw), .q(pin_s)
    );
    dcf_sync #(.W(DATA_W), .RST_VAL('0)) u_data_sync (
        .clk(aclk), .rst_n(aresetn), .d(write_data_bus), .q(wdata_s)
    );

    assign mrs_act = ~pin_s[9];
    assign prs_act = ~pin_s[8];
    assign rt_act = ~pin_s[7];
    assign si_s = pin_s[6];
    assign wen = ~pin_s[5];
    assign ren = ~pin_s[4];
    assign oe_act = ~pin_s[3];
    assign serial_load_enable = ~pin_s[2];
    assign ld_act = ~pin_s[1];
    assign tie_s = pin_s[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wclk_d_q <= 1'b0; // link clocks idle low: no false edge after reset
            rclk_d_q <= 1'b0;
        end else begin
            wclk_d_q <= pin_s[11];
            rclk_d_q <= pin_s[10];
        end
    end

    assign wr_edge = pin_s[11] & ~wclk_d_q;
    assign rd_tr = pin_s[10] ^ rclk_d_q;
    assign rd_edge = rd_tr & pin_s[10];

    // ------------------------------------------------------------
    // configuration and thresholds
    // ------------------------------------------------------------
    logic fall_through_mode_q, serial_q, wsel_q, rsel_q;
    logic [ADDR_W-1:0] empty_off_q, full_off_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fall_through_mode_q <= 1'b0;
            serial_q <= 1'b0;
            wsel_q <= 1'b0;
            empty_off_q <= ADDR_W'(OFF_DEF_LO);
            full_off_q <= ADDR_W'(OFF_DEF_LO);
        end else if (mrs_act) begin
            fall_through_mode_q <= si_s;
            serial_q <= ~ld_act;
            wsel_q <= 1'b0;
            empty_off_q <= ld_act ? ADDR_W'(OFF_DEF_LO) : ADDR_W'(OFF_DEF_HI);
            full_off_q <= ld_act ? ADDR_W'(OFF_DEF_LO) : ADDR_W'(OFF_DEF_HI);
        end else if (prs_act) begin
            wsel_q <= 1'b0;
        end else if (wr_edge && ld_act && serial_load_enable && serial_q) begin
            {full_off_q, empty_off_q} <= {full_off_q[ADDR_W-2:0], empty_off_q, si_s};
        end else if (wr_edge && ld_act && wen && !serial_q) begin
            if (wsel_q) begin
                full_off_q <= wdata_s[ADDR_W-1:0];
            end else begin
                empty_off_q <= wdata_s[ADDR_W-1:0];
            end
            wsel_q <= ~wsel_q;
        end
    end

    // ------------------------------------------------------------
    // write side
    // ------------------------------------------------------------
    logic [PW-1:0] wptr_q, rptr_q, count;
    logic full, empty, mem_we;
    logic [DATA_W-1:0] mem_rd;

    assign count = wptr_q - rptr_q;
    assign full = (count == DEPTH_V);
    assign empty = (count == '0);
    assign mem_we = aresetn && !mrs_act && !prs_act && wr_edge && wen && !ld_act && !full;

    always_ff @(posedge aclk) begin
        if (!aresetn || mrs_act || prs_act) begin
            wptr_q <= '0;
        end else if (mem_we) begin
            wptr_q <= wptr_q + 1'b1;
        end
    end

    dcf_mem #(.W(DATA_W), .AW(ADDR_W)) u_mem (
        .clk(aclk),
        .we(mem_we),
        .waddr(wptr_q[ADDR_W-1:0]),
        .wdata(wdata_s),
        .raddr(rptr_q[ADDR_W-1:0]),
        .rdata(mem_rd)
    );

    // ------------------------------------------------------------
    // read side
    // ------------------------------------------------------------
    logic [DATA_W-1:0] out_q;
    logic valid_q, retx_q;
    logic [1:0] ft_cnt_q;

    // fall-through keeps the presented word outside the count, so flags
    // describe the memory alone; a trade for a simpler pointer path
    always_ff @(posedge aclk) begin
        if (!aresetn || mrs_act || prs_act) begin
            rptr_q <= '0;
            out_q <= '0;
            valid_q <= 1'b0;
            retx_q <= 1'b0;
            ft_cnt_q <= '0;
            rsel_q <= 1'b0;
        end else if (rd_edge && rt_act) begin
            rptr_q <= '0;
            valid_q <= 1'b0;
            retx_q <= 1'b1;
            ft_cnt_q <= '0;
        end else begin
            if (rd_edge) begin
                retx_q <= 1'b0;
            end
            if (rd_edge && ren && ld_act) begin
                out_q <= DATA_W'(rsel_q ? full_off_q : empty_off_q);
                rsel_q <= ~rsel_q;
            end else if (!fall_through_mode_q) begin
                if (rd_edge && ren && !empty) begin
                    out_q <= mem_rd;
                    rptr_q <= rptr_q + 1'b1;
                end
            end else if (valid_q) begin
                if (rd_edge && ren) begin
                    if (!empty) begin
                        out_q <= mem_rd;
                        rptr_q <= rptr_q + 1'b1;
                    end else begin
                        valid_q <= 1'b0;
                    end
                end
            end else if (empty) begin
                ft_cnt_q <= '0;
            end else if (rd_tr) begin
                if (ft_cnt_q == 2'(FT_TRANSITIONS - 1)) begin
                    out_q <= mem_rd;
                    rptr_q <= rptr_q + 1'b1;
                    valid_q <= 1'b1;
                    ft_cnt_q <= '0;
                end else begin
                    ft_cnt_q <= ft_cnt_q + 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // flags and output drive
    // ------------------------------------------------------------
    logic gate_q, afull, aempty, half;

    assign afull = (count > PW'(DEPTH_V - {1'b0, full_off_q}));
    assign aempty = (count < {1'b0, empty_off_q});
    assign half = (count > HALF_V);
    assign full_or_input_ready_n = fall_through_mode_q ? full : ~full;
    assign empty_or_data_valid_n = fall_through_mode_q ? ~valid_q : ~(empty | retx_q);
    assign almost_full_flag_n = ~afull;
    assign almost_empty_flag_n = ~aempty;
    assign half_full_flag_n = ~half;
    assign read_data_bus = out_q;
    assign read_data_bus_oe_n = ~(oe_act & gate_q);

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
    logic [31:0] awaddr_q, wdata_q, rdata_q, rd_word;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q, rd_resp;

    assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
    assign s_axi_wready = ~w_hold_q & ~bvalid_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            gate_q <= CTRL_RESET[CTRL_GATE_BIT];
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (aw_hold_q && w_hold_q && !bvalid_q) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                bvalid_q <= 1'b1;
                if (awaddr_q == REG_CTRL) begin
                    bresp_q <= RESP_OKAY;
                    if (wstrb_q[0]) begin
                        gate_q <= wdata_q[CTRL_GATE_BIT];
                    end
                end else if (awaddr_q == REG_STATUS || awaddr_q == REG_EMPTY_OFF ||
                             awaddr_q == REG_FULL_OFF) begin
                    bresp_q <= RESP_OKAY;
                end else begin
                    bresp_q <= RESP_SLVERR;
                end
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_comb begin
        rd_word = '0;
        rd_resp = RESP_OKAY;
        if (s_axi_araddr == REG_CTRL) begin
            rd_word[CTRL_GATE_BIT] = gate_q;
        end else if (s_axi_araddr == REG_STATUS) begin
            rd_word[PW-1:0] = count;
            rd_word[STAT_FULL_BIT] = full;
            rd_word[STAT_EMPTY_BIT] = empty;
            rd_word[STAT_AFULL_BIT] = afull;
            rd_word[STAT_AEMPTY_BIT] = aempty;
            rd_word[STAT_HALF_BIT] = half;
            rd_word[STAT_FALL_THROUGH_MODE_BIT] = fall_through_mode_q;
            rd_word[STAT_SERIAL_BIT] = serial_q;
            rd_word[STAT_TIE_BIT] = tie_s;
            rd_word[STAT_VALID_BIT] = valid_q;
        end else if (s_axi_araddr == REG_EMPTY_OFF) begin
            rd_word[ADDR_W-1:0] = empty_off_q;
        end else if (s_axi_araddr == REG_FULL_OFF) begin
            rd_word[ADDR_W-1:0] = full_off_q;
        end else begin
            rd_resp = RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_resp;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_mrs_clear;
        mrs_act |=> (wptr_q == '0) && (rptr_q == '0) && (out_q == '0);
    endproperty
    a_mrs_clear: assert property (p_mrs_clear)
        else $error("master reset left pointers or output set");

    property p_prs_keep;
        prs_act && !mrs_act |=> $stable(empty_off_q) && $stable(full_off_q) && $stable(fall_through_mode_q);
    endproperty
    a_prs_keep: assert property (p_prs_keep)
        else $error("partial reset disturbed configuration");

    property p_rewind;
        rd_edge && rt_act && !mrs_act && !prs_act
            |=> (rptr_q == '0) && wptr_q == $past(wptr_q) + PW'($past(mem_we)) && retx_q;
    endproperty
    a_rewind: assert property (p_rewind)
        else $error("rewind did not reset read pointer alone");

    property p_default_sel;
        mrs_act ##1 !mrs_act |-> empty_off_q == (serial_q ? ADDR_W'(OFF_DEF_HI) : ADDR_W'(OFF_DEF_LO));
    endproperty
    a_default_sel: assert property (p_default_sel)
        else $error("default threshold does not match method");

    property p_serial_shift;
        !mrs_act && !prs_act && wr_edge && ld_act && serial_load_enable && serial_q
            |=> empty_off_q[0] == $past(si_s) && empty_off_q[ADDR_W-1:1] == $past(empty_off_q[ADDR_W-2:0]);
    endproperty
    a_serial_shift: assert property (p_serial_shift)
        else $error("serial load did not shift one bit");

    property p_no_write_full;
        wr_edge && wen && full && !mrs_act && !prs_act |=> $stable(wptr_q);
    endproperty
    a_no_write_full: assert property (p_no_write_full)
        else $error("write accepted while full");

    property p_ld_gate;
        wr_edge && wen && ld_act && !mrs_act && !prs_act |=> $stable(wptr_q);
    endproperty
    a_ld_gate: assert property (p_ld_gate)
        else $error("load access reached data memory");

    property p_ft_latency;
        fall_through_mode_q && !valid_q && !empty && rd_tr && ft_cnt_q == 2'd0
            && !mrs_act && !prs_act |=> !valid_q;
    endproperty
    a_ft_latency: assert property (p_ft_latency)
        else $error("fall-through word appeared too early");

    property p_oe;
        !gate_q || output_enable_n && $past(output_enable_n, 2) && $past(output_enable_n, 3)
            |-> read_data_bus_oe_n;
    endproperty
    a_oe: assert property (p_oe)
        else $error("read data driven while disabled");
endmodule
`default_nettype wire

// ### src/dcf_pkg.sv
// dcf_pkg: shared constants of the dual-clock flagged buffer
// assumes: imported whole by every design module of the block
package dcf_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int DATA_W_DEF = 18;
    localparam int ADDR_W_DEF = 17;

    // ------------------------------------------------------------
    // thresholds and timing
    // ------------------------------------------------------------
    localparam int OFF_DEF_LO = 127;
    localparam int OFF_DEF_HI = 1023;
    localparam int FT_TRANSITIONS = 3;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [31:0] REG_CTRL = 32'h0000_0000;
    localparam logic [31:0] REG_STATUS = 32'h0000_0004;
    localparam logic [31:0] REG_EMPTY_OFF = 32'h0000_0008;
    localparam logic [31:0] REG_FULL_OFF = 32'h0000_000c;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam int CTRL_GATE_BIT = 0;
    localparam int STAT_FULL_BIT = 20;
    localparam int STAT_EMPTY_BIT = 21;
    localparam int STAT_AFULL_BIT = 22;
    localparam int STAT_AEMPTY_BIT = 23;
    localparam int STAT_HALF_BIT = 24;
    localparam int STAT_FALL_THROUGH_MODE_BIT = 25;
    localparam int STAT_SERIAL_BIT = 26;
    localparam int STAT_TIE_BIT = 27;
    localparam int STAT_VALID_BIT = 28;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### src/dcf_sync.sv
// dcf_sync: two-stage synchroniser for a vector of pin levels
// assumes: each bit is an independent level; no bit-to-bit coherence
`timescale 1ns/10ps
`default_nettype none
module dcf_sync
    import dcf_pkg::*;
#(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // first stage is read by the second stage only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ### src/dcf_mem.sv
// dcf_mem: word store of the buffer, one write port, one read port
// assumes: single clock; read is combinational from the array
`timescale 1ns/10ps
`default_nettype none
module dcf_mem
    import dcf_pkg::*;
#(
    parameter int W = DATA_W_DEF,
    parameter int AW = ADDR_W_DEF
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [W-1:0] rdata
);
    logic [W-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = mem[raddr];
endmodule
`default_nettype wire

// ### verification/dcf_link_peer.sv
// far-side writer and reader logic that drives the buffer's link pins
// assumes: aclk only paces the start of a cycle; link clocks stand low between cycles
`timescale 1ns/10ps
`default_nettype none
module dcf_link_peer
    import dcf_pkg::*;
(
    input wire logic aclk,
    input wire logic [17:0] read_data_bus,
    output var logic write_clock,
    output var logic read_clock,
    output var logic write_enable_n,
    output var logic read_enable_n,
    output var logic serial_load_enable_n,
    output var logic threshold_access_load_n,
    output var logic fall_through_select_serial_in,
    output var logic rewind_read_pointer_n,
    output var logic [17:0] write_data_bus
);
    // ------
    // pin cycles
    // ------
    initial begin
        {write_clock, read_clock, fall_through_select_serial_in} = 3'h0;
        {write_enable_n, read_enable_n, serial_load_enable_n} = 3'h7;
        {threshold_access_load_n, rewind_read_pointer_n} = 2'h3;
        write_data_bus = 18'h0;
    end
    // pins change by non-blocking assignment on an aclk edge; the link
    // clock edge follows half a link period later
    task automatic cfg(input logic ld_n, input logic si);
        @(posedge aclk);
        threshold_access_load_n <= ld_n;
        fall_through_select_serial_in <= si;
    endtask
    task automatic wcyc(input logic wen_n, input logic sen_n, input logic ld_n, input logic si,
            input logic [17:0] d);
        cfg(ld_n, si);
        {write_enable_n, serial_load_enable_n} <= {wen_n, sen_n};
        write_data_bus <= d;
        #62.5;
        write_clock = 1'b1;
        #62.5;
        write_clock = 1'b0;
        {write_enable_n, serial_load_enable_n, threshold_access_load_n} = 3'h7;
        // a released bus must not keep showing the last word
        write_data_bus = ~d;
    endtask
    task automatic rcyc(input logic ren_n, input logic ld_n, input logic rt_n,
            output logic [17:0] q);
        cfg(ld_n, fall_through_select_serial_in);
        {read_enable_n, rewind_read_pointer_n} <= {ren_n, rt_n};
        #62.5;
        read_clock = 1'b1;
        #62.5;
        q = read_data_bus;
        read_clock = 1'b0;
        {read_enable_n, rewind_read_pointer_n, threshold_access_load_n} = 3'h7;
    endtask
endmodule
`default_nettype wire

// ### verification/dcf_fifo_test.sv
// self-checking bench: link pins through the peer model, registers over AXI4-Lite
// assumes: 10 address bits, so a full fill stays short and defaults stay exact
`timescale 1ns/10ps
`default_nettype none
module dcf_fifo_test
    import dcf_pkg::*;
;
    localparam int AW = 10;
    localparam int DEPTH = 1 << AW;
    logic aclk = 1'b0, aresetn = 1'b0, master_reset_n = 1'b1, partial_reset_n = 1'b1;
    logic output_enable_n = 1'b0, unused_tie_pin = 1'b0;
    wire logic write_clock, read_clock, write_enable_n, read_enable_n, serial_load_enable_n;
    wire logic threshold_access_load_n, fall_through_select_serial_in, rewind_read_pointer_n;
    wire logic [17:0] write_data_bus, read_data_bus;
    wire logic read_data_bus_oe_n, full_or_input_ready_n, empty_or_data_valid_n;
    wire logic almost_full_flag_n, almost_empty_flag_n, half_full_flag_n;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    int fails = 0, n_tests = 0, i;
    logic [31:0] d;
    logic [17:0] q;
    logic [1:0] r;
    logic [2*AW-1:0] sv;

    always #4 aclk = ~aclk;
    dcf_fifo #(.ADDR_W(AW)) i_dut (.*);
    dcf_link_peer i_peer (.*);

    // ------
    // tasks
    // ------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ready and valid are sampled at the falling edge, so the handshake edge is never raced
    task automatic wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic ta, tw, tk;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, v};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(negedge aclk);
            {ta, tw} = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready};
            {tk, rs} = {s_axi_bvalid, s_axi_bresp};
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end while (!tk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ta, tv;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(negedge aclk);
            {ta, tv, v, rs} = {s_axi_arvalid & s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
        end while (!tv);
        s_axi_rready <= 1'b0;
    endtask
    task automatic mreset(input logic ld_n, input logic ft);
        i_peer.cfg(ld_n, ft);
        @(posedge aclk);
        master_reset_n <= 1'b0;
        repeat (8) @(posedge aclk);
        master_reset_n <= 1'b1;
        repeat (8) @(posedge aclk);
        i_peer.cfg(1'b1, 1'b0);
    endtask

    // ------
    // tests
    // ------
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        mreset(1'b0, 1'b0);
        chk(read_data_bus, 32'h0);
        chk(empty_or_data_valid_n, 32'h0);
        rd(REG_CTRL, d, r);
        chk(d, CTRL_RESET);
        rd(REG_EMPTY_OFF, d, r);
        chk(d, OFF_DEF_LO);
        rd(REG_STATUS, d, r);
        chk(d[STAT_SERIAL_BIT:STAT_FALL_THROUGH_MODE_BIT], 32'h0);
        rd(32'h10, d, r);
        chk({r, d[29:0]}, {RESP_SLVERR, 30'h0});
        wr(32'h10, 32'h1, r);
        chk(r, RESP_SLVERR);
        i_peer.rcyc(1'b0, 1'b1, 1'b1, q);
        chk(q, 32'h0);
        i_peer.wcyc(1'b0, 1'b1, 1'b0, 1'b0, 18'h5);
        i_peer.wcyc(1'b0, 1'b1, 1'b0, 1'b0, 18'h3);
        chk(empty_or_data_valid_n, 32'h0);
        i_peer.rcyc(1'b0, 1'b0, 1'b1, q);
        chk(q, 32'h5);
        i_peer.rcyc(1'b0, 1'b0, 1'b1, q);
        chk(q, 32'h3);
        for (i = 0; i <= DEPTH; i++) begin
            i_peer.wcyc(1'b0, 1'b1, 1'b1, 1'b0, 18'h2a5 + 18'(i));
            if (i == 3 || i == 4) chk(almost_empty_flag_n, 32'(i == 4));
            if (i == DEPTH / 2 - 1 || i == DEPTH / 2) chk(half_full_flag_n, 32'(i < DEPTH / 2));
            if (i == DEPTH - 4 || i == DEPTH - 3) chk(almost_full_flag_n, 32'(i == DEPTH - 4));
            if (i == DEPTH - 2 || i == DEPTH - 1) chk(full_or_input_ready_n, 32'(i == DEPTH - 2));
        end
        rd(REG_STATUS, d, r);
        chk(d[17:0], DEPTH);
        i_peer.rcyc(1'b0, 1'b1, 1'b1, q);
        chk(q, 32'h2a5);
        chk(full_or_input_ready_n, 32'h1);
        i_peer.rcyc(1'b1, 1'b1, 1'b0, q);
        chk(empty_or_data_valid_n, 32'h0);
        i_peer.rcyc(1'b0, 1'b1, 1'b1, q);
        chk({empty_or_data_valid_n, q}, {1'b1, 18'h2a5});
        @(posedge aclk);
        partial_reset_n <= 1'b0;
        repeat (8) @(posedge aclk);
        partial_reset_n <= 1'b1;
        repeat (8) @(posedge aclk);
        chk({empty_or_data_valid_n, read_data_bus}, 32'h0);
        rd(REG_EMPTY_OFF, d, r);
        chk(d, 32'h5);
        mreset(1'b1, 1'b1);
        rd(REG_STATUS, d, r);
        chk(d[STAT_SERIAL_BIT:STAT_FALL_THROUGH_MODE_BIT], 32'h3);
        rd(REG_FULL_OFF, d, r);
        chk(d, OFF_DEF_HI);
        chk({full_or_input_ready_n, empty_or_data_valid_n}, 32'h1);
        i_peer.wcyc(1'b0, 1'b1, 1'b1, 1'b0, 18'h2b3c1);
        i_peer.rcyc(1'b1, 1'b1, 1'b1, q);
        chk(empty_or_data_valid_n, 32'h1);
        i_peer.rcyc(1'b1, 1'b1, 1'b1, q);
        chk({empty_or_data_valid_n, q}, {1'b0, 18'h2b3c1});
        sv = {10'h15a, 10'h077};
        for (i = 2 * AW - 1; i >= 0; i--) i_peer.wcyc(1'b1, 1'b0, 1'b0, sv[i], 18'h0);
        rd(REG_EMPTY_OFF, d, r);
        chk(d, 32'h77);
        rd(REG_FULL_OFF, d, r);
        chk(d, 32'h15a);
        chk(read_data_bus_oe_n, 32'h0);
        output_enable_n <= 1'b1;
        repeat (4) @(posedge aclk);
        chk(read_data_bus_oe_n, 32'h1);
        output_enable_n <= 1'b0;
        wr(REG_CTRL, 32'h0, r);
        repeat (4) @(posedge aclk);
        chk(read_data_bus_oe_n, 32'h1);
        conclude();
    end
    initial begin
        #600000;
        fails++;
        conclude();
    end
endmodule
`default_nettype wire
